// file: design/cfa_defs.vh
// shared constants for the card file access command front end
`ifndef CFA_DEFS_VH
`define CFA_DEFS_VH

// ----------------------------------------
// command selects on cmd_sel_i
// ----------------------------------------
`define CFA_CMD_CWD_QUERY 3'h0
`define CFA_CMD_LIST_BEGIN 3'h1
`define CFA_CMD_LIST_ADVANCE 3'h2
`define CFA_CMD_CWD_CHANGE 3'h3
`define CFA_CMD_FILE_OPEN 3'h4
`define CFA_CMD_FILE_CLOSE 3'h5
`define CFA_CMD_DIR_MAKE 3'h6
`define CFA_CMD_FILE_WRITE 3'h7

// ----------------------------------------
// media operations on med_op_o
// ----------------------------------------
`define CFA_OP_CAL 3'h0
`define CFA_OP_FIRST 3'h1
`define CFA_OP_NEXT 3'h2
`define CFA_OP_CHDIR 3'h3
`define CFA_OP_OPEN 3'h4
`define CFA_OP_CLOSE 3'h5

// ----------------------------------------
// error codes
// ----------------------------------------
`define CFA_ERR_NONE 16'h0000
`define CFA_ERR_NOT_FOUND 16'h0B90
`define CFA_ERR_LISTING_END 16'h0B96
`define CFA_ERR_BAD_ENTRY 16'h0AF9
`define CFA_ERR_UNIMPL 16'h0001
`define CFA_ERR_BAD_PATH 16'h0002

// ----------------------------------------
// path buffers, attribute field and file data fifo
// ----------------------------------------
`define CFA_PATH_MAX 6'h20
`define CFA_SEP_CHAR 8'h2F
`define CFA_ATTR_DIR_BIT 4
`define CFA_FIFO_DEPTH 4
`define CFA_FIFO_WIDTH 8

// ----------------------------------------
// timing
// ----------------------------------------
`define CFA_CLK_KHZ 100000
`define CFA_WL_JOIN_MS 3000
`define CFA_WL_JOIN_CYC (`CFA_WL_JOIN_MS * `CFA_CLK_KHZ)

`endif

// file: design/cfa_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module cfa_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire mclk_i,
	input wire arst_n_i,
	input wire clr_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem[rp_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always @(posedge mclk_i) begin
		if (push) begin
			mem[wp_q] <= in_data_i;
		end
	end

	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (clr_i) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // cfa_fifo

// file: design/cfa_card_access.v
// command interpreter for browsing and reading files on the memory card
`timescale 1ns/100ps
`include "cfa_defs.vh"
module cfa_card_access #(
	parameter [31:0] WL_JOIN_CYC = `CFA_WL_JOIN_CYC
) (
	input wire mclk_i,
	input wire arst_n_i,
	input wire cmd_wr_i,
	input wire [2:0] cmd_sel_i,
	output wire cmd_ready_o,
	output reg err_valid_o,
	output reg [15:0] err_code_o,
	input wire path_len_wr_i,
	input wire [7:0] path_len_i,
	input wire path_byte_wr_i,
	input wire [7:0] path_byte_i,
	input wire path_out_rd_i,
	output reg [7:0] path_out_length_o,
	output reg [7:0] path_out_byte_o,
	output reg [7:0] item_attribute_mask_o,
	output reg [31:0] item_byte_size_o,
	input wire sector_count_rd_i,
	output reg [15:0] sector_byte_count_o,
	output reg [15:0] sectors_per_cluster_o,
	output reg [31:0] total_cluster_count_o,
	output reg [31:0] free_cluster_count_o,
	input wire stream_req_i,
	output reg stream_enable_o,
	output reg stream_refused_o,
	output reg cal_default_o,
	input wire wl_join_i,
	input wire card_present_i,
	output wire wl_window_o,
	output reg wl_retry_o,
	output wire med_req_o,
	output reg [2:0] med_op_o,
	output reg [7:0] med_path_len_o,
	input wire [4:0] med_path_addr_i,
	output reg [7:0] med_path_byte_o,
	input wire med_done_i,
	input wire [15:0] med_err_i,
	input wire med_byte_valid_i,
	input wire [7:0] med_byte_i,
	output wire med_byte_ready_o,
	input wire med_entry_dir_i,
	input wire [7:0] med_entry_attr_i,
	input wire [31:0] med_entry_size_i,
	input wire [15:0] med_sector_size_i,
	input wire [15:0] med_spc_i,
	input wire [31:0] med_total_i,
	input wire [31:0] med_free_i,
	output wire file_data_valid_o,
	input wire file_data_ready_i,
	output wire [7:0] file_data_o
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [2:0] S_INIT0 = 3'h0;
	localparam [2:0] S_INIT1 = 3'h1;
	localparam [2:0] S_IDLE = 3'h2;
	localparam [2:0] S_WAIT = 3'h3;
	localparam [2:0] S_RCWD = 3'h4;
	localparam [2:0] S_RSEP = 3'h5;
	localparam [2:0] S_RPIN = 3'h6;
	localparam [2:0] S_MED = 3'h7;

	function uses_bus;
		input [2:0] sel;
		begin
			uses_bus = (sel != `CFA_CMD_CWD_QUERY) && (sel != `CFA_CMD_DIR_MAKE) &&
				(sel != `CFA_CMD_FILE_WRITE);
		end
	endfunction

	function needs_resolve;
		input [2:0] op;
		begin
			needs_resolve = (op == `CFA_OP_CHDIR) || (op == `CFA_OP_OPEN);
		end
	endfunction

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// two banks so a failed change leaves the old directory intact
	reg [7:0] cwd_mem [0:63];
	reg [7:0] pin_mem [0:31];
	reg [7:0] name_mem [0:31];

	reg [2:0] st_q;
	reg [2:0] op_q;
	reg cwd_sel_q;
	reg [5:0] cwd_len_q;
	reg cwd_valid_q;
	reg [5:0] pin_len_q;
	reg [5:0] pin_wp_q;
	reg [5:0] ri_q;
	reg [5:0] wi_q;
	reg [5:0] new_len_q;
	reg [5:0] nm_wp_q;
	reg path_bank_q;
	reg out_src_q;
	reg [5:0] out_rp_q;
	reg list_ok_q;
	reg file_open_q;
	reg cal_done_q;
	reg fifo_clr_q;
	reg [1:0] wl_sync_q;
	reg [1:0] card_sync_q;
	reg wl_prev_q;
	reg [31:0] wl_cnt_q;
	reg wl_hit_q;

	reg cw_we;
	reg [5:0] cw_addr;
	reg [7:0] cw_data;
	wire scr;
	wire [7:0] cwd_last;
	wire wl_rise;
	wire win;
	wire bus_cmd;
	wire fifo_in_ready;
	wire to_fifo;

	assign scr = ~cwd_sel_q;
	assign cwd_last = cwd_mem[{cwd_sel_q, cwd_len_q[4:0] - 5'h02}];
	assign cmd_ready_o = (st_q == S_IDLE);
	assign med_req_o = (st_q == S_MED);
	assign bus_cmd = cmd_wr_i && cmd_ready_o && uses_bus(cmd_sel_i);

	// ----------------------------------------
	// wireless join window
	// ----------------------------------------
	// pins pass two flops first
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wl_sync_q <= 2'h0;
			card_sync_q <= 2'h0;
			wl_prev_q <= 1'b0;
		end else begin
			wl_sync_q <= {wl_sync_q[0], wl_join_i};
			card_sync_q <= {card_sync_q[0], card_present_i};
			wl_prev_q <= wl_sync_q[1];
		end
	end

	assign wl_rise = wl_sync_q[1] & ~wl_prev_q;
	assign win = (wl_cnt_q != 32'h0000_0000);
	assign wl_window_o = win;

	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wl_cnt_q <= 32'h0000_0000;
			wl_retry_o <= 1'b0;
			wl_hit_q <= 1'b0;
		end else begin
			wl_retry_o <= 1'b0;
			wl_hit_q <= win & med_req_o;
			if (wl_rise) begin
				wl_cnt_q <= WL_JOIN_CYC;
			end else if (win && (bus_cmd || (med_req_o && !wl_hit_q))) begin
				// join is spoiled; the window starts over at once
				wl_cnt_q <= WL_JOIN_CYC;
				wl_retry_o <= 1'b1;
			end else if (win) begin
				wl_cnt_q <= wl_cnt_q - 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------
	// directory buffer writes
	// ----------------------------------------
	always @* begin
		cw_we = 1'b0;
		cw_addr = {scr, wi_q[4:0]};
		cw_data = 8'h00;
		case (st_q)
			S_INIT0: begin
				cw_we = 1'b1;
				cw_addr = 6'h00;
				cw_data = `CFA_SEP_CHAR;
			end
			S_INIT1: begin
				cw_we = 1'b1;
				cw_addr = 6'h01;
			end
			S_RCWD: begin
				cw_we = (ri_q < cwd_len_q - 6'h01) && !wi_q[5];
				cw_data = cwd_mem[{cwd_sel_q, ri_q[4:0]}];
			end
			S_RSEP: begin
				cw_we = (cwd_last != `CFA_SEP_CHAR) && !wi_q[5];
				cw_data = `CFA_SEP_CHAR;
			end
			S_RPIN: begin
				cw_we = !wi_q[5];
				cw_data = pin_mem[ri_q[4:0]];
			end
			default: begin
				cw_we = 1'b0;
			end
		endcase
	end

	always @(posedge mclk_i) begin
		if (cw_we) begin
			cwd_mem[cw_addr] <= cw_data;
		end
		if (path_byte_wr_i && !pin_wp_q[5]) begin
			pin_mem[pin_wp_q[4:0]] <= path_byte_i;
		end
		if (med_req_o && med_byte_valid_i && !file_open_q && !nm_wp_q[5]) begin
			name_mem[nm_wp_q[4:0]] <= med_byte_i;
		end
	end

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= S_INIT0;
			op_q <= `CFA_OP_CAL;
			cwd_sel_q <= 1'b0;
			cwd_len_q <= 6'h00;
			cwd_valid_q <= 1'b0;
			pin_len_q <= 6'h00;
			pin_wp_q <= 6'h00;
			ri_q <= 6'h00;
			wi_q <= 6'h00;
			new_len_q <= 6'h00;
			nm_wp_q <= 6'h00;
			path_bank_q <= 1'b0;
			out_src_q <= 1'b0;
			out_rp_q <= 6'h00;
			path_out_length_o <= 8'h00;
			path_out_byte_o <= 8'h00;
			med_path_len_o <= 8'h00;
			list_ok_q <= 1'b0;
			file_open_q <= 1'b0;
			cal_done_q <= 1'b0;
			cal_default_o <= 1'b0;
			fifo_clr_q <= 1'b0;
			err_valid_o <= 1'b0;
			err_code_o <= `CFA_ERR_NONE;
			item_attribute_mask_o <= 8'h00;
			item_byte_size_o <= 32'h0000_0000;
		end else begin
			err_valid_o <= 1'b0;
			fifo_clr_q <= 1'b0;
			if (path_len_wr_i) begin
				pin_len_q <= (path_len_i > {2'h0, `CFA_PATH_MAX}) ? 6'h00 : path_len_i[5:0];
				pin_wp_q <= 6'h00;
			end else if (path_byte_wr_i && !pin_wp_q[5]) begin
				pin_wp_q <= pin_wp_q + 6'h01;
			end
			if (path_out_rd_i) begin
				// past the end the reader sees zeros
				if ({2'h0, out_rp_q} < path_out_length_o) begin
					path_out_byte_o <= out_src_q ? name_mem[out_rp_q[4:0]] :
						cwd_mem[{cwd_sel_q, out_rp_q[4:0]}];
				end else begin
					path_out_byte_o <= 8'h00;
				end
				if (!out_rp_q[5]) begin
					out_rp_q <= out_rp_q + 6'h01;
				end
			end
			if (!card_sync_q[1]) begin
				cwd_valid_q <= 1'b0;
			end
			case (st_q)
				S_INIT0: begin
					st_q <= S_INIT1;
				end
				S_INIT1: begin
					cwd_len_q <= 6'h02;
					cwd_sel_q <= 1'b0;
					op_q <= `CFA_OP_CAL;
					st_q <= S_WAIT;
				end
				S_IDLE: begin
					if (cmd_wr_i) begin
						case (cmd_sel_i)
							`CFA_CMD_CWD_QUERY: begin
								err_valid_o <= 1'b1;
								if (cwd_valid_q) begin
									err_code_o <= `CFA_ERR_NONE;
									path_out_length_o <= {2'h0, cwd_len_q};
									out_src_q <= 1'b0;
									out_rp_q <= 6'h00;
								end else begin
									err_code_o <= `CFA_ERR_NOT_FOUND;
								end
							end
							`CFA_CMD_LIST_BEGIN: begin
								op_q <= `CFA_OP_FIRST;
								st_q <= S_WAIT;
							end
							`CFA_CMD_LIST_ADVANCE: begin
								if (list_ok_q) begin
									op_q <= `CFA_OP_NEXT;
									st_q <= S_WAIT;
								end else begin
									err_valid_o <= 1'b1;
									err_code_o <= `CFA_ERR_BAD_ENTRY;
								end
							end
							`CFA_CMD_CWD_CHANGE, `CFA_CMD_FILE_OPEN: begin
								if (pin_len_q == 6'h00 || pin_wp_q < pin_len_q) begin
									err_valid_o <= 1'b1;
									err_code_o <= `CFA_ERR_BAD_PATH;
								end else begin
									op_q <= (cmd_sel_i == `CFA_CMD_FILE_OPEN) ?
										`CFA_OP_OPEN : `CFA_OP_CHDIR;
									st_q <= S_WAIT;
								end
							end
							`CFA_CMD_FILE_CLOSE: begin
								file_open_q <= 1'b0;
								fifo_clr_q <= 1'b1;
								op_q <= `CFA_OP_CLOSE;
								st_q <= S_WAIT;
							end
							default: begin
								// no card traffic at all for these
								err_valid_o <= 1'b1;
								err_code_o <= `CFA_ERR_UNIMPL;
							end
						endcase
					end
				end
				S_WAIT: begin
					if (!win) begin
						ri_q <= 6'h00;
						wi_q <= 6'h00;
						nm_wp_q <= 6'h00;
						path_bank_q <= cwd_sel_q;
						med_path_len_o <= {2'h0, cwd_len_q};
						if (!needs_resolve(op_q)) begin
							st_q <= S_MED;
						end else if (pin_mem[0] == `CFA_SEP_CHAR) begin
							st_q <= S_RPIN;
						end else begin
							st_q <= S_RCWD;
						end
					end
				end
				S_RCWD: begin
					if (ri_q < cwd_len_q - 6'h01) begin
						ri_q <= ri_q + 6'h01;
						wi_q <= wi_q + 6'h01;
					end else begin
						st_q <= S_RSEP;
					end
				end
				S_RSEP: begin
					ri_q <= 6'h00;
					if (cwd_last != `CFA_SEP_CHAR) begin
						wi_q <= wi_q + 6'h01;
					end
					st_q <= S_RPIN;
				end
				S_RPIN: begin
					if (wi_q[5]) begin
						err_valid_o <= 1'b1;
						err_code_o <= `CFA_ERR_BAD_PATH;
						st_q <= S_IDLE;
					end else if (ri_q == pin_len_q - 6'h01) begin
						new_len_q <= wi_q + 6'h01;
						med_path_len_o <= {2'h0, wi_q + 6'h01};
						path_bank_q <= scr;
						st_q <= S_MED;
					end else begin
						ri_q <= ri_q + 6'h01;
						wi_q <= wi_q + 6'h01;
					end
				end
				S_MED: begin
					if (med_byte_valid_i && !file_open_q && !nm_wp_q[5]) begin
						nm_wp_q <= nm_wp_q + 6'h01;
					end
					if (med_done_i) begin
						st_q <= S_IDLE;
						err_valid_o <= (op_q != `CFA_OP_CAL);
						err_code_o <= med_err_i;
						case (op_q)
							`CFA_OP_CAL: begin
								cal_done_q <= 1'b1;
								cal_default_o <= (med_err_i != `CFA_ERR_NONE);
								cwd_valid_q <= card_sync_q[1];
							end
							`CFA_OP_FIRST, `CFA_OP_NEXT: begin
								list_ok_q <= (med_err_i == `CFA_ERR_NONE);
								if (med_err_i == `CFA_ERR_NONE) begin
									path_out_length_o <= {2'h0, nm_wp_q};
									out_src_q <= 1'b1;
									out_rp_q <= 6'h00;
									item_attribute_mask_o <= med_entry_attr_i;
									item_attribute_mask_o[`CFA_ATTR_DIR_BIT] <=
										med_entry_dir_i;
									item_byte_size_o <= med_entry_size_i;
								end else if (op_q == `CFA_OP_FIRST) begin
									err_code_o <= `CFA_ERR_NOT_FOUND;
								end else if (med_err_i != `CFA_ERR_BAD_ENTRY) begin
									err_code_o <= `CFA_ERR_LISTING_END;
								end
							end
							`CFA_OP_CHDIR: begin
								if (med_err_i == `CFA_ERR_NONE) begin
									cwd_sel_q <= scr;
									cwd_len_q <= new_len_q;
									cwd_valid_q <= 1'b1;
									list_ok_q <= 1'b0;
								end
							end
							`CFA_OP_OPEN: begin
								file_open_q <= (med_err_i == `CFA_ERR_NONE);
							end
							default: begin
								file_open_q <= 1'b0;
							end
						endcase
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// media path read, disk snapshot, stream gate
	// ----------------------------------------
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			med_op_o <= `CFA_OP_CAL;
			med_path_byte_o <= 8'h00;
			sector_byte_count_o <= 16'h0000;
			sectors_per_cluster_o <= 16'h0000;
			total_cluster_count_o <= 32'h0000_0000;
			free_cluster_count_o <= 32'h0000_0000;
			stream_enable_o <= 1'b0;
			stream_refused_o <= 1'b0;
		end else begin
			med_op_o <= op_q;
			med_path_byte_o <= cwd_mem[{path_bank_q, med_path_addr_i}];
			stream_refused_o <= 1'b0;
			if (sector_count_rd_i) begin
				sector_byte_count_o <= med_sector_size_i;
				sectors_per_cluster_o <= med_spc_i;
				total_cluster_count_o <= med_total_i;
				free_cluster_count_o <= med_free_i;
			end
			if (stream_req_i) begin
				// streaming only on top of good calibration
				stream_enable_o <= cal_done_q && !cal_default_o;
				stream_refused_o <= !cal_done_q || cal_default_o;
			end
		end
	end

	// ----------------------------------------
	// file data path
	// ----------------------------------------
	// bytes stall at the card when the host stops reading
	assign to_fifo = file_open_q && !med_req_o;
	assign med_byte_ready_o = to_fifo ? fifo_in_ready : 1'b1;

	cfa_fifo #(
		.WIDTH(`CFA_FIFO_WIDTH),
		.DEPTH(`CFA_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.clr_i(fifo_clr_q),
		.in_valid_i(med_byte_valid_i & to_fifo),
		.in_ready_o(fifo_in_ready),
		.in_data_i(med_byte_i),
		.out_valid_o(file_data_valid_o),
		.out_ready_i(file_data_ready_i),
		.out_data_o(file_data_o)
	);
endmodule // cfa_card_access

// file: verif/cfa_media_model.sv
// media side model: answers card operations and streams file bytes
`timescale 1ns/100ps
module cfa_media_model (
	input wire mclk_i,
	input wire arst_n_i,
	input wire req_i,
	input wire [2:0] op_i,
	input wire [15:0] cal_err_i,
	input wire [15:0] first_err_i,
	input wire [15:0] next_err_i,
	input wire [3:0] lat_i,
	input wire [7:0] nbytes_i,
	input wire byte_ready_i,
	output reg done_o,
	output reg [15:0] err_o,
	output wire byte_valid_o,
	output wire [7:0] byte_o
);
	reg [3:0] cnt_q;
	reg open_q;
	reg [7:0] sent_q;
	// bytes flow only while open and idle
	assign byte_valid_o = open_q && !req_i && sent_q != nbytes_i;
	// released data shows the inverse so a stale value never passes
	assign byte_o = byte_valid_o ? 8'h40 + sent_q : ~(8'h40 + sent_q);
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= 4'h0;
			done_o <= 1'h0;
			err_o <= 16'h0000;
			open_q <= 1'h0;
			sent_q <= 8'h00;
		end else begin
			done_o <= 1'h0;
			err_o <= ~err_o;
			if (byte_valid_o && byte_ready_i)
				sent_q <= sent_q + 8'h01;
			if (req_i && !done_o) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == lat_i) begin
					cnt_q <= 4'h0;
					done_o <= 1'h1;
					err_o <= op_i == 3'h0 ? cal_err_i : op_i == 3'h1 ? first_err_i :
						op_i == 3'h2 ? next_err_i : 16'h0000;
					if (op_i[2:1] == 2'h2)
						open_q <= !op_i[0];
					if (op_i == 3'h4)
						sent_q <= 8'h00;
				end
			end
		end
	end
endmodule // cfa_media_model

// file: verif/cfa_card_access_properties.sv
// assertion checker for the card file access front end
`timescale 1ns/100ps
module cfa_card_access_props (
	input wire mclk_i,
	input wire arst_n_i,
	input wire cmd_wr_i,
	input wire [2:0] cmd_sel_i,
	input wire cmd_ready_o,
	input wire err_valid_o,
	input wire [15:0] err_code_o,
	input wire [7:0] item_attribute_mask_o,
	input wire sector_count_rd_i,
	input wire [15:0] sector_byte_count_o,
	input wire [31:0] free_cluster_count_o,
	input wire [15:0] med_sector_size_i,
	input wire [31:0] med_free_i,
	input wire stream_req_i,
	input wire stream_enable_o,
	input wire stream_refused_o,
	input wire cal_default_o,
	input wire wl_window_o,
	input wire wl_retry_o,
	input wire med_req_o,
	input wire [2:0] med_op_o,
	input wire med_done_i,
	input wire [15:0] med_err_i,
	input wire med_entry_dir_i
);
	// ----------
	// properties
	// ----------
	default clocking dc @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	wire acc = cmd_wr_i && cmd_ready_o;
	wire lst = med_op_o == 3'h1 || med_op_o == 3'h2;
	property p_query;
		acc && cmd_sel_i == 3'h0 |=> err_valid_o;
	endproperty
	a_query: assert property (p_query) else $error("query not answered");
	property p_unimpl;
		acc && cmd_sel_i[2:1] == 2'h3 |=> err_valid_o && err_code_o == 16'h0001 && !med_req_o;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("bad unsupported answer");
	property p_answer;
		acc |-> ##[1:400] err_valid_o;
	endproperty
	a_answer: assert property (p_answer) else $error("command without answer");
	property p_dir;
		med_done_i && med_req_o && lst && med_err_i == 16'h0000
			|=> item_attribute_mask_o[4] == $past(med_entry_dir_i);
	endproperty
	a_dir: assert property (p_dir) else $error("directory bit wrong");
	property p_snap;
		sector_count_rd_i |=> sector_byte_count_o == $past(med_sector_size_i)
			&& free_cluster_count_o == $past(med_free_i);
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot wrong");
	property p_hold;
		!sector_count_rd_i |=> $stable(sector_byte_count_o) && $stable(free_cluster_count_o);
	endproperty
	a_hold: assert property (p_hold) else $error("snapshot moved");
	// a bus op may start inside the window only together with a retry
	property p_quiet;
		wl_window_o && !med_req_o |=> !med_req_o || !wl_window_o || wl_retry_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("bus used in window");
	property p_retry;
		$rose(wl_window_o) && med_req_o |-> ##[0:3] wl_retry_o;
	endproperty
	a_retry: assert property (p_retry) else $error("no join retry");
	property p_refuse;
		stream_req_i && cal_default_o |=> stream_refused_o && !stream_enable_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("stream not refused");
	c_list: cover property (acc && cmd_sel_i == 3'h1);
	c_retry: cover property (wl_retry_o);
	c_refuse: cover property (stream_refused_o);
endmodule // cfa_card_access_props

bind cfa_card_access cfa_card_access_props u_props (
	.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_wr_i(cmd_wr_i), .cmd_sel_i(cmd_sel_i),
	.cmd_ready_o(cmd_ready_o), .err_valid_o(err_valid_o), .err_code_o(err_code_o),
	.item_attribute_mask_o(item_attribute_mask_o), .sector_count_rd_i(sector_count_rd_i),
	.sector_byte_count_o(sector_byte_count_o), .free_cluster_count_o(free_cluster_count_o),
	.med_sector_size_i(med_sector_size_i), .med_free_i(med_free_i), .stream_req_i(stream_req_i),
	.stream_enable_o(stream_enable_o), .stream_refused_o(stream_refused_o),
	.cal_default_o(cal_default_o), .wl_window_o(wl_window_o), .wl_retry_o(wl_retry_o),
	.med_req_o(med_req_o), .med_op_o(med_op_o), .med_done_i(med_done_i),
	.med_err_i(med_err_i), .med_entry_dir_i(med_entry_dir_i)
);

// file: verif/testbench.sv
// self-checking bench for the card file access front end
`timescale 1ns/100ps
module testbench;
	logic mclk_i, arst_n_i = '0, cmd_wr_i = '0, path_len_wr_i = '0, path_byte_wr_i = '0;
	logic path_out_rd_i = '0, sector_count_rd_i = '0, stream_req_i = '0, wl_join_i = '0;
	logic file_data_ready_i = '0, med_entry_dir_i = '0, card = '1;
	logic [2:0] cmd_sel_i = '0;
	logic [7:0] path_len_i = '0, path_byte_i = '0;
	logic [15:0] med_sector_size_i, med_spc_i, cal_err = '0, first_err = '0, next_err = '0;
	logic [31:0] med_total_i, med_free_i;
	logic [3:0] lat = 4'h3;
	wire cmd_ready_o, err_valid_o, stream_enable_o, stream_refused_o, cal_default_o;
	wire wl_window_o, wl_retry_o, med_req_o, med_done_i, med_byte_valid_i, med_byte_ready_o;
	wire file_data_valid_o;
	wire [2:0] med_op_o;
	wire [7:0] path_out_length_o, path_out_byte_o, item_attribute_mask_o, med_byte_i, file_data_o;
	wire [15:0] err_code_o, sector_byte_count_o, sectors_per_cluster_o, med_err_i;
	wire [31:0] total_cluster_count_o, free_cluster_count_o, item_byte_size_o;
	integer n_fail = 0, comparisons = 0, n_retry = 0, i, j, r0;

	// ----------
	// design and media side
	// ----------
	cfa_card_access #(.WL_JOIN_CYC(32'h32)) dut_u (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_wr_i(cmd_wr_i), .cmd_sel_i(cmd_sel_i),
		.cmd_ready_o(cmd_ready_o), .err_valid_o(err_valid_o), .err_code_o(err_code_o),
		.path_len_wr_i(path_len_wr_i), .path_len_i(path_len_i), .path_byte_wr_i(path_byte_wr_i),
		.path_byte_i(path_byte_i), .path_out_rd_i(path_out_rd_i),
		.path_out_length_o(path_out_length_o), .path_out_byte_o(path_out_byte_o),
		.item_attribute_mask_o(item_attribute_mask_o), .item_byte_size_o(item_byte_size_o),
		.sector_count_rd_i(sector_count_rd_i), .sector_byte_count_o(sector_byte_count_o),
		.sectors_per_cluster_o(sectors_per_cluster_o), .total_cluster_count_o(total_cluster_count_o),
		.free_cluster_count_o(free_cluster_count_o), .stream_req_i(stream_req_i),
		.stream_enable_o(stream_enable_o), .stream_refused_o(stream_refused_o),
		.cal_default_o(cal_default_o), .wl_join_i(wl_join_i), .card_present_i(card),
		.wl_window_o(wl_window_o), .wl_retry_o(wl_retry_o), .med_req_o(med_req_o),
		.med_op_o(med_op_o), .med_path_len_o(), .med_path_addr_i(5'h00), .med_path_byte_o(),
		.med_done_i(med_done_i), .med_err_i(med_err_i), .med_byte_valid_i(med_byte_valid_i),
		.med_byte_i(med_byte_i), .med_byte_ready_o(med_byte_ready_o),
		.med_entry_dir_i(med_entry_dir_i), .med_entry_attr_i(8'h21),
		.med_entry_size_i(32'h6), .med_sector_size_i(med_sector_size_i),
		.med_spc_i(med_spc_i), .med_total_i(med_total_i), .med_free_i(med_free_i),
		.file_data_valid_o(file_data_valid_o), .file_data_ready_i(file_data_ready_i),
		.file_data_o(file_data_o)
	);
	cfa_media_model media_u (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_i(med_req_o), .op_i(med_op_o),
		.cal_err_i(cal_err), .first_err_i(first_err), .next_err_i(next_err), .lat_i(lat),
		.nbytes_i(8'h06), .byte_ready_i(med_byte_ready_o), .done_o(med_done_i),
		.err_o(med_err_i), .byte_valid_o(med_byte_valid_i), .byte_o(med_byte_i)
	);

	initial begin
		mclk_i = 1'h0;
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i)
		if (wl_retry_o === 1'h1)
			n_retry++;

	// ----------
	// shared tasks
	// ----------
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons++;
			if (got !== exp) begin
				n_fail++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task cmd(input [2:0] s, input [15:0] e);
		integer k;
		begin
			for (k = 0; k < 2000 && cmd_ready_o !== 1'h1; k++)
				@(negedge mclk_i);
			cmd_wr_i = 1'h1;
			cmd_sel_i = s;
			@(negedge mclk_i);
			cmd_wr_i = 1'h0;
			for (k = 0; k < 2000 && err_valid_o !== 1'h1; k++)
				@(negedge mclk_i);
			chk({err_valid_o, err_code_o}, {1'h1, e});
			@(negedge mclk_i);
		end
	endtask
	// length counts the null byte
	task path(input [31:0] s);
		integer k;
		begin
			path_len_i = 8'h04;
			path_len_wr_i = 1'h1;
			@(negedge mclk_i);
			path_len_wr_i = 1'h0;
			for (k = 3; k >= 0; k--) begin
				path_byte_i = s[8*k+:8];
				path_byte_wr_i = 1'h1;
				@(negedge mclk_i);
			end
			path_byte_wr_i = 1'h0;
		end
	endtask
	task rdout(input [7:0] n, input [31:0] s);
		integer k;
		begin
			chk(path_out_length_o, n);
			for (k = 3; k >= 0; k--) begin
				path_out_rd_i = 1'h1;
				@(negedge mclk_i);
				path_out_rd_i = 1'h0;
				chk(path_out_byte_o, s[8*k+:8]);
				@(negedge mclk_i);
			end
		end
	endtask
	task strm(input [2:0] e);
		begin
			stream_req_i = 1'h1;
			@(negedge mclk_i);
			stream_req_i = 1'h0;
			chk({stream_enable_o, stream_refused_o, cal_default_o}, e);
		end
	endtask

	// ----------
	// scenarios
	// ----------
	task t_list;
		begin
			med_entry_dir_i = 1'h1;
			cmd(3'h1, 16'h0000);
			chk({item_attribute_mask_o, item_byte_size_o[23:0]}, 32'h3100_0006);
			med_entry_dir_i = 1'h0;
			cmd(3'h2, 16'h0000);
			chk(item_attribute_mask_o[4], 1'h0);
			next_err = 16'h0005;
			cmd(3'h2, 16'h0B96);
			cmd(3'h2, 16'h0AF9);
			first_err = 16'h0005;
			cmd(3'h1, 16'h0B90);
		end
	endtask
	task t_disk;
		begin
			med_sector_size_i = 16'h0200;
			med_spc_i = 16'h0040;
			med_total_i = 32'h0001_0000;
			med_free_i = 32'h0000_8000;
			sector_count_rd_i = 1'h1;
			@(negedge mclk_i);
			sector_count_rd_i = 1'h0;
			med_spc_i = 16'h0001;
			med_total_i = 32'h0000_0002;
			@(negedge mclk_i);
			chk({sector_byte_count_o, sectors_per_cluster_o}, 32'h0200_0040);
			chk(total_cluster_count_o ^ free_cluster_count_o, 32'h0001_8000);
		end
	endtask
	// fifo fills while the reader stalls
	task t_file;
		begin
			path(32'h2F46_3100);
			cmd(3'h4, 16'h0000);
			repeat (20) @(negedge mclk_i);
			chk({file_data_valid_o, med_byte_ready_o}, 2'h2);
			for (i = 0; i < 6; i++) begin
				@(negedge mclk_i);
				for (j = 0; j < 50 && file_data_valid_o !== 1'h1; j++)
					@(negedge mclk_i);
				chk(file_data_o, 8'h40 + i);
				file_data_ready_i = 1'h1;
				@(negedge mclk_i);
				file_data_ready_i = 1'h0;
			end
			@(negedge mclk_i);
			chk(file_data_valid_o, 1'h0);
			cmd(3'h5, 16'h0000);
		end
	endtask
	task t_window;
		begin
			first_err = 16'h0000;
			wl_join_i = 1'h1;
			repeat (6) @(negedge mclk_i);
			chk(wl_window_o, 1'h1);
			wl_join_i = 1'h0;
			cmd(3'h1, 16'h0000);
			chk(wl_window_o, 1'h0);
			lat = 4'hC;
			r0 = n_retry;
			fork
				cmd(3'h1, 16'h0000);
				begin
					repeat (5) @(negedge mclk_i);
					wl_join_i = 1'h1;
				end
			join
			chk(n_retry - r0, 1);
			lat = 4'h3;
			wl_join_i = 1'h0;
		end
	endtask

	task final_report;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, n_fail);
			if (n_fail == 0 && comparisons > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_fail++;
		final_report;
	end
	initial begin
		repeat (12) @(negedge mclk_i);
		arst_n_i = 1'h1;
		cmd(3'h0, 16'h0000);
		rdout(8'h02, 32'h2F00_0000);
		strm(3'h4);
		t_list;
		path(32'h2F44_3100);
		cmd(3'h3, 16'h0000);
		cmd(3'h0, 16'h0000);
		rdout(8'h04, 32'h2F44_3100);
		path(32'h6162_6300);
		cmd(3'h3, 16'h0000);
		cmd(3'h0, 16'h0000);
		chk(path_out_length_o, 8'h08);
		cmd(3'h6, 16'h0001);
		cmd(3'h7, 16'h0001);
		t_disk;
		t_file;
		t_window;
		cal_err = 16'h0001;
		card = 1'h0;
		arst_n_i = 1'h0;
		repeat (3) @(negedge mclk_i);
		arst_n_i = 1'h1;
		cmd(3'h0, 16'h0B90);
		cmd(3'h6, 16'h0001);
		strm(3'h3);
		final_report;
	end
endmodule // testbench
